// file: common/etc_map.svh
// Purpose: Register offsets, field positions and reset values of the 8-bit timer core
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   Included by the package users; definitions only
`ifndef ETC_MAP_SVH
`define ETC_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ETC_OFF_CTRL_A   8'h00
`define ETC_OFF_CTRL_B   8'h04
`define ETC_OFF_COUNT    8'h08
`define ETC_OFF_CMP_A    8'h0c
`define ETC_OFF_CMP_B    8'h10
`define ETC_OFF_FLAG     8'h14
`define ETC_OFF_MASK     8'h18
`define ETC_OFF_POWER    8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ETC_CA_MODE_LO   0
`define ETC_CA_COMB_LO   4
`define ETC_CA_COMA_LO   6
`define ETC_CB_CS_LO     0
`define ETC_CB_MODE2     3
`define ETC_CB_FOCB      6
`define ETC_CB_FOCA      7
`define ETC_FL_OVF       0
`define ETC_FL_CMPA      1
`define ETC_FL_CMPB      2

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define ETC_RST_BYTE     8'h00
`define ETC_RST_POWER    1'b1
`define ETC_BOTTOM       8'h00
`define ETC_MAX          8'hff
`define ETC_CLK_NS       4

`endif

// file: common/etc_pkg.sv
// Purpose: Types shared by the 8-bit timer core
// Assumes: Offsets and fields live in etc_map.svh
// Notes:   Nothing here is imported; use etc_pkg::name
package etc_pkg;

    typedef enum logic [2:0] {
        ETC_M_NORMAL, ETC_M_PWM_PC, ETC_M_CTC, ETC_M_FAST,
        ETC_M_RSV4, ETC_M_PWM_PC_A, ETC_M_RSV6, ETC_M_FAST_A
    } etc_mode_e;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
    } etc_values_s;

    typedef struct packed {
        logic       ovf;
        logic       cmpa;
        logic       cmpb;
    } etc_events_s;

endpackage

// file: rtl/etc_timer.sv
// Purpose: 8-bit timer/counter core with two compares, AHB-Lite registers, one irq
// Assumes: Single-word AHB-Lite transfers; external count pin asynchronous
// Notes:   Prescaler taps counted from hclk; no wait states on the bus
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "etc_map.svh"

// Function
// - Eight-bit count with bottom and max indications
// - Top is 0xFF or compare A by mode
// - Tick clears, increments or decrements counter
// - Three-bit select picks prescaler tap or pin
// - Select zero stops the counter
// - Software reads and writes count anytime
// - Software count write beats clear and step
// - Mode bits split across control A and B
// - Overflow flag per mode, unmasked raises irq
// - Continuous compares set flag A or B
// - One flag register, one mask register
// - Compare results drive waveform output pins
// - Mode 0 counts up, wraps, flags overflow
// - Mode 2 clears on compare A match
// - Compare buffering in every mode but normal and CTC
// - Compare flags cleared by service or one-write
module etc_timer #(
    parameter int PRESC_W = 10
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Interrupt service acknowledges and request
    input  wire logic        ack_ovf,
    input  wire logic        ack_cmpa,
    input  wire logic        ack_cmpb,
    output logic             irq,
    // Pins
    input  wire logic        external_count_pin,
    output logic             compare_output_a_pin,
    output logic             compare_output_b_pin
);

    initial begin
        if (PRESC_W < 10 || PRESC_W > 16) begin
            $error("PRESC_W must lie in 10..16");
        end
    end

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       rd_ok;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                wr_addr <= haddr[7:0];
            end
        end
    end
    assign rd_ok     = hsel && hready && htrans[1] && !hwrite;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic [7:0] wdat;
    logic       wr_ca, wr_cb, wr_cnt, wr_oa, wr_ob, wr_fl, wr_mk, wr_pw;
    assign wdat   = hwdata[7:0];
    assign wr_ca  = wr_pend && wr_addr == `ETC_OFF_CTRL_A;
    assign wr_cb  = wr_pend && wr_addr == `ETC_OFF_CTRL_B;
    assign wr_cnt = wr_pend && wr_addr == `ETC_OFF_COUNT;
    assign wr_oa  = wr_pend && wr_addr == `ETC_OFF_CMP_A;
    assign wr_ob  = wr_pend && wr_addr == `ETC_OFF_CMP_B;
    assign wr_fl  = wr_pend && wr_addr == `ETC_OFF_FLAG;
    assign wr_mk  = wr_pend && wr_addr == `ETC_OFF_MASK;
    assign wr_pw  = wr_pend && wr_addr == `ETC_OFF_POWER;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0] control_register_a;
    logic [7:0] control_register_b;
    logic [2:0] timer_mask_register;
    logic       timer_power_reduction_bit;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_register_a        <= `ETC_RST_BYTE;
            control_register_b        <= `ETC_RST_BYTE;
            timer_mask_register       <= 3'h0;
            timer_power_reduction_bit <= `ETC_RST_POWER;
        end else begin
            if (wr_ca) begin
                control_register_a <= wdat & 8'hf3;
            end
            // Force strobes are not stored: they read as zero
            if (wr_cb) begin
                control_register_b <= wdat & 8'h0f;
            end
            if (wr_mk) begin
                timer_mask_register <= wdat[2:0];
            end
            if (wr_pw) begin
                timer_power_reduction_bit <= wdat[0];
            end
        end
    end

    etc_pkg::etc_mode_e mode_field;
    assign mode_field = etc_pkg::etc_mode_e'({control_register_b[`ETC_CB_MODE2],
                                              control_register_a[`ETC_CA_MODE_LO +: 2]});
    logic [2:0] clock_select_field;
    assign clock_select_field = control_register_b[`ETC_CB_CS_LO +: 3];
    logic [1:0] compare_output_action_a, compare_output_action_b;
    assign compare_output_action_a = control_register_a[`ETC_CA_COMA_LO +: 2];
    assign compare_output_action_b = control_register_a[`ETC_CA_COMB_LO +: 2];
    logic force_a, force_b;
    assign force_a = wr_cb && wdat[`ETC_CB_FOCA];
    assign force_b = wr_cb && wdat[`ETC_CB_FOCB];

    logic is_pwm, is_pc, top_is_a;
    assign is_pwm   = mode_field != etc_pkg::ETC_M_NORMAL && mode_field != etc_pkg::ETC_M_CTC;
    assign is_pc    = mode_field == etc_pkg::ETC_M_PWM_PC || mode_field == etc_pkg::ETC_M_PWM_PC_A;
    assign top_is_a = mode_field == etc_pkg::ETC_M_CTC || mode_field == etc_pkg::ETC_M_PWM_PC_A
                      || mode_field == etc_pkg::ETC_M_FAST_A;

    // ------------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------------
    logic [PRESC_W-1:0] presc;
    logic [2:0]         pin_sync;
    logic               enabled;
    assign enabled = !timer_power_reduction_bit;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc    <= '0;
            pin_sync <= 3'h0;
        end else begin
            presc    <= enabled ? presc + 1'b1 : '0;
            pin_sync <= {pin_sync[1:0], external_count_pin};
        end
    end

    logic timer_tick;
    logic pin_fall, pin_rise;
    assign pin_fall = pin_sync[2] && !pin_sync[1];
    assign pin_rise = !pin_sync[2] && pin_sync[1];
    always_comb begin
        timer_tick = 1'b0;
        unique case (clock_select_field)
            3'h0: timer_tick = 1'b0;
            3'h1: timer_tick = 1'b1;
            3'h2: timer_tick = presc[2:0] == 3'h7;
            3'h3: timer_tick = presc[5:0] == 6'h3f;
            3'h4: timer_tick = presc[7:0] == 8'hff;
            3'h5: timer_tick = presc[9:0] == 10'h3ff;
            3'h6: timer_tick = pin_fall;
            3'h7: timer_tick = pin_rise;
        endcase
        if (!enabled) begin
            timer_tick = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Compare registers
    // ------------------------------------------------------------------
    etc_pkg::etc_values_s val;
    logic [7:0] buf_a, buf_b;
    logic [7:0] top_val;
    logic       at_top, at_bottom, at_max, dir_down, upd_point;
    assign top_val   = top_is_a ? val.cmp_a : `ETC_MAX;
    assign at_bottom = val.count == `ETC_BOTTOM;
    assign at_max    = val.count == `ETC_MAX;
    assign at_top    = val.count == top_val;
    assign upd_point = timer_tick && (is_pc ? at_top : at_bottom);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_a     <= `ETC_RST_BYTE;
            buf_b     <= `ETC_RST_BYTE;
            val.cmp_a <= `ETC_RST_BYTE;
            val.cmp_b <= `ETC_RST_BYTE;
        end else begin
            if (wr_oa) begin
                buf_a <= wdat;
            end
            if (wr_ob) begin
                buf_b <= wdat;
            end
            if (!is_pwm) begin
                if (wr_oa) begin
                    val.cmp_a <= wdat;
                end
                if (wr_ob) begin
                    val.cmp_b <= wdat;
                end
            end else if (upd_point) begin
                val.cmp_a <= buf_a;
                val.cmp_b <= buf_b;
            end
        end
    end

    // ------------------------------------------------------------------
    // Counter unit
    // ------------------------------------------------------------------
    logic next_dir_down;
    always_comb begin
        next_dir_down = dir_down;
        if (!is_pc) begin
            next_dir_down = 1'b0;
        end else if (at_top) begin
            next_dir_down = 1'b1;
        end else if (at_bottom) begin
            next_dir_down = 1'b0;
        end
    end

    logic cnt_blk;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            val.count <= `ETC_RST_BYTE;
            dir_down  <= 1'b0;
            cnt_blk   <= 1'b0;
        end else begin
            if (wr_cnt) begin
                val.count <= wdat;
                cnt_blk   <= 1'b1;
            end else if (timer_tick) begin
                cnt_blk  <= 1'b0;
                dir_down <= next_dir_down;
                if (!is_pc && at_top && top_is_a) begin
                    val.count <= `ETC_BOTTOM;
                end else if (is_pc && next_dir_down) begin
                    val.count <= val.count - 8'h01;
                end else if (!is_pc && at_top) begin
                    val.count <= `ETC_BOTTOM;
                end else begin
                    val.count <= val.count + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Events and flags
    // ------------------------------------------------------------------
    etc_pkg::etc_events_s ev;
    logic [2:0] timer_flag_register;
    logic [2:0] clr_fl, set_fl;
    assign ev.ovf  = timer_tick && (is_pc ? (at_bottom && dir_down)
                                  : (mode_field == etc_pkg::ETC_M_CTC ? at_max : at_top));
    // continuous compares, blocked after a count write
    assign ev.cmpa = timer_tick && !cnt_blk && val.count == val.cmp_a;
    assign ev.cmpb = timer_tick && !cnt_blk && val.count == val.cmp_b;
    assign set_fl  = {ev.cmpb, ev.cmpa, ev.ovf};
    assign clr_fl  = (wr_fl ? wdat[2:0] : 3'h0) | {ack_cmpb, ack_cmpa, ack_ovf};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_flag_register <= 3'h0;
        end else begin
            // Set wins over a coincident clear
            timer_flag_register <= (timer_flag_register & ~clr_fl) | set_fl;
        end
    end
    assign irq = |(timer_flag_register & timer_mask_register);

    // ------------------------------------------------------------------
    // Waveform generator
    // ------------------------------------------------------------------
    logic [1:0] wave;
    logic [1:0] match;
    logic [1:0] act [2];
    logic [1:0] frc;
    assign match  = {ev.cmpb, ev.cmpa};
    assign act[0] = compare_output_action_a;
    assign act[1] = compare_output_action_b;
    assign frc    = {force_b, force_a};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_wave
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    wave[gi] <= 1'b0;
                end else if (!is_pwm && (match[gi] || frc[gi])) begin
                    unique case (act[gi])
                        2'h0: wave[gi] <= wave[gi];
                        2'h1: wave[gi] <= !wave[gi];
                        2'h2: wave[gi] <= 1'b0;
                        2'h3: wave[gi] <= 1'b1;
                    endcase
                end else if (is_pwm && act[gi][1] && match[gi]) begin
                    wave[gi] <= is_pc ? (act[gi][0] ^ !next_dir_down) : act[gi][0];
                end else if (is_pwm && act[gi][1] && !is_pc && timer_tick && at_top) begin
                    wave[gi] <= !act[gi][0];
                end
            end
        end
    endgenerate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_output_a_pin <= 1'b0;
            compare_output_b_pin <= 1'b0;
        end else begin
            compare_output_a_pin <= (|compare_output_action_a) ? wave[0] : 1'b0;
            compare_output_b_pin <= (|compare_output_action_b) ? wave[1] : 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] rsel;
    always_comb begin
        rsel = 8'h00;
        unique case (haddr[7:0])
            `ETC_OFF_CTRL_A: rsel = control_register_a;
            `ETC_OFF_CTRL_B: rsel = control_register_b;
            `ETC_OFF_COUNT:  rsel = val.count;
            `ETC_OFF_CMP_A:  rsel = is_pwm ? buf_a : val.cmp_a;
            `ETC_OFF_CMP_B:  rsel = is_pwm ? buf_b : val.cmp_b;
            `ETC_OFF_FLAG:   rsel = {5'h00, timer_flag_register};
            `ETC_OFF_MASK:   rsel = {5'h00, timer_mask_register};
            `ETC_OFF_POWER:  rsel = {7'h00, timer_power_reduction_bit};
            default:         rsel = 8'h00;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_ok) begin
            hrdata <= {24'h00_0000, rsel};
        end
    end

endmodule

// file: tb/etc_timer_properties.sv
// Purpose: Port-level properties of the 8-bit timer core
// Assumes: Zero-wait AHB-Lite slave, one clock domain
// Notes:   Shadows of mask and control A follow the bus writes
`timescale 1ns/100ps
`include "etc_map.svh"
module etc_timer_properties (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Interrupt and pins
    input wire logic        irq,
    input wire logic        compare_output_a_pin,
    input wire logic        compare_output_b_pin
);
    logic       rd_ap;
    logic       dp_wr;
    logic [7:0] dp_addr;
    logic [2:0] mask_sh;
    logic [7:0] ctla_sh;

    assign rd_ap = hsel && hready && htrans[1] && !hwrite;

    // ------------------------------------------------------------------
    // Shadows, loaded at the data-phase edge like the registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr   <= 1'b0;
            dp_addr <= 8'h00;
            mask_sh <= 3'h0;
            ctla_sh <= 8'h00;
        end else begin
            dp_wr   <= hsel && hready && htrans[1] && hwrite;
            dp_addr <= haddr[7:0];
            mask_sh <= (dp_wr && dp_addr == `ETC_OFF_MASK) ? hwdata[2:0] : mask_sh;
            ctla_sh <= (dp_wr && dp_addr == `ETC_OFF_CTRL_A) ? hwdata[7:0] : ctla_sh;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus not ready or not okay");
    property p_byte; hrdata[31:8] == 24'h0; endproperty
    a_byte: assert property (p_byte) else $error("read data above bit 7");
    property p_unmapped; rd_ap && haddr[7:0] > `ETC_OFF_POWER |=> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_strobe; rd_ap && haddr[7:0] == `ETC_OFF_CTRL_B |=> hrdata[7:6] == 2'b00; endproperty
    a_strobe: assert property (p_strobe) else $error("force strobes read back");
    property p_flags; rd_ap && haddr[7:0] == `ETC_OFF_FLAG |=> hrdata[7:3] == 5'h0; endproperty
    a_flags: assert property (p_flags) else $error("flag register spare bits set");
    property p_power; rd_ap && haddr[7:0] == `ETC_OFF_POWER |=> hrdata[7:1] == 7'h0; endproperty
    a_power: assert property (p_power) else $error("power register spare bits set");
    property p_irq_mask; mask_sh == 3'h0 |-> !irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq with all sources masked");
    property p_pin_a;
        ctla_sh[7:6] == 2'b00 && $past(ctla_sh[7:6]) == 2'b00 |-> !compare_output_a_pin;
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("output A driven with no action");
    property p_pin_b;
        ctla_sh[5:4] == 2'b00 && $past(ctla_sh[5:4]) == 2'b00 |-> !compare_output_b_pin;
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("output B driven with no action");
endmodule

bind etc_timer etc_timer_properties u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .irq, .compare_output_a_pin, .compare_output_b_pin
);

// file: tb/tb.sv
// Purpose: Self-checking bench of the 8-bit timer core over AHB-Lite
// Assumes: Zero-wait slave; prescaler phase unknown, so rates are ranged
// Notes:   Compare outputs are checked through forced matches in normal mode
`timescale 1ns/100ps
`include "etc_map.svh"
module tb;
    logic        hclk;
    logic        hresetn  = 1'b0;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'b00;
    logic        hwrite   = 1'b0;
    logic [2:0]  hsize    = 3'h2;
    logic [31:0] hwdata   = 32'h0;
    logic        ack_ovf  = 1'b0;
    logic        ack_cmpa = 1'b0;
    logic        ack_cmpb = 1'b0;
    logic        pin_ext  = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        pin_a;
    logic        pin_b;
    logic [31:0] rd;
    int          err_count;
    int          num_checks;
    int          div [4] = '{8, 64, 256, 1024};

    etc_timer #(.PRESC_W(10)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .ack_ovf, .ack_cmpa, .ack_cmpb, .irq,
        .external_count_pin(pin_ext), .compare_output_a_pin(pin_a),
        .compare_output_b_pin(pin_b)
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One single transfer; waits on hready in both phases
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, addr};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        xfer(1'b1, addr, wd);
    endtask

    task automatic rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        xfer(1'b0, addr, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic finish_test;
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge hclk);
        err_count++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 9; i++) rdchk("reset value", 8'(i * 4), (i == 7) ? 32'h1 : 32'h0);
        wr(`ETC_OFF_CTRL_B, 32'h1);
        repeat (20) @(posedge hclk);
        rdchk("count powered down", `ETC_OFF_COUNT, 32'h0);
        wr(`ETC_OFF_CTRL_B, 32'h0);
        wr(`ETC_OFF_POWER, 32'h0);
        wr(`ETC_OFF_COUNT, 32'h5a);
        repeat (20) @(posedge hclk);
        rdchk("count stopped", `ETC_OFF_COUNT, 32'h5a);
        wr(`ETC_OFF_CMP_A, 32'h30);
        wr(`ETC_OFF_CMP_B, 32'h40);
        rdchk("compare A direct", `ETC_OFF_CMP_A, 32'h30);
        wr(`ETC_OFF_COUNT, 32'hfa);
        wr(`ETC_OFF_FLAG, 32'h7);
        rdchk("flags stopped", `ETC_OFF_FLAG, 32'h0);
        wr(`ETC_OFF_CTRL_B, 32'h1);
        repeat (10) @(posedge hclk);
        rdchk("overflow flag", `ETC_OFF_FLAG, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`ETC_OFF_MASK, 32'h7);
        #1 chk("irq unmasked", {31'h0, irq}, 32'h1);
        @(posedge hclk);
        ack_ovf <= 1'b1;
        @(posedge hclk);
        ack_ovf <= 1'b0;
        #1 chk("irq after service", {31'h0, irq}, 32'h0);
        repeat (60) @(posedge hclk);
        rdchk("compare flags", `ETC_OFF_FLAG, 32'h6);
        @(posedge hclk);
        ack_cmpa <= 1'b1;
        @(posedge hclk);
        ack_cmpa <= 1'b0;
        rdchk("service clears A", `ETC_OFF_FLAG, 32'h4);
        wr(`ETC_OFF_FLAG, 32'h4);
        rdchk("write one clears B", `ETC_OFF_FLAG, 32'h0);
        // Written value must win over the step of the same edge
        wr(`ETC_OFF_COUNT, 32'h80);
        xfer(1'b0, `ETC_OFF_COUNT, 32'h0);
        chk("written count kept", {31'h0, (rd[7:0] - 8'h80) < 8'h5}, 32'h1);
        wr(`ETC_OFF_CTRL_B, 32'h0);
        wr(`ETC_OFF_COUNT, 32'h0);
        wr(`ETC_OFF_CMP_A, 32'h5);
        wr(`ETC_OFF_CMP_B, 32'h3);
        wr(`ETC_OFF_CTRL_A, 32'h2);
        wr(`ETC_OFF_FLAG, 32'h7);
        wr(`ETC_OFF_CTRL_B, 32'h1);
        repeat (300) @(posedge hclk);
        rdchk("clear on match flags", `ETC_OFF_FLAG, 32'h6);
        xfer(1'b0, `ETC_OFF_COUNT, 32'h0);
        chk("clear on match top", {31'h0, rd[7:0] <= 8'h5}, 32'h1);
        wr(`ETC_OFF_CTRL_B, 32'h0);
        @(posedge hclk);
        ack_cmpb <= 1'b1;
        @(posedge hclk);
        ack_cmpb <= 1'b0;
        rdchk("service clears B", `ETC_OFF_FLAG, 32'h2);
        // Fast PWM: a compare write waits in the buffer until bottom
        wr(`ETC_OFF_CTRL_A, 32'h3);
        wr(`ETC_OFF_FLAG, 32'h7);
        wr(`ETC_OFF_CMP_A, 32'h20);
        rdchk("compare A buffer read", `ETC_OFF_CMP_A, 32'h20);
        wr(`ETC_OFF_COUNT, 32'h10);
        wr(`ETC_OFF_CTRL_B, 32'h1);
        repeat (40) @(posedge hclk);
        wr(`ETC_OFF_CTRL_B, 32'h0);
        rdchk("compare A buffered", `ETC_OFF_FLAG, 32'h0);
        // Forced compare toggles both outputs
        wr(`ETC_OFF_CTRL_A, 32'h50);
        wr(`ETC_OFF_CTRL_B, 32'hc0);
        @(posedge hclk);
        #1 chk("forced outputs", {30'h0, pin_b, pin_a}, 32'h3);
        wr(`ETC_OFF_CTRL_A, 32'h0);
        // Four rising and three falling pin edges per pass
        for (int cs = 6; cs < 8; cs++) begin
            wr(`ETC_OFF_CTRL_B, 32'h0);
            pin_ext <= 1'b0;
            wr(`ETC_OFF_COUNT, 32'h0);
            wr(`ETC_OFF_CTRL_B, 32'(cs));
            repeat (7) begin
                pin_ext <= ~pin_ext;
                repeat (8) @(posedge hclk);
            end
            rdchk("pin edge count", `ETC_OFF_COUNT, (cs == 7) ? 32'h4 : 32'h3);
        end
        // Prescaler phase is free running, so allow one tick either way
        for (int cs = 2; cs < 6; cs++) begin
            wr(`ETC_OFF_CTRL_B, 32'h0);
            wr(`ETC_OFF_COUNT, 32'h0);
            wr(`ETC_OFF_CTRL_B, 32'(cs));
            repeat (6 * div[cs - 2]) @(posedge hclk);
            xfer(1'b0, `ETC_OFF_COUNT, 32'h0);
            chk("prescaled count", {31'h0, (rd[7:0] - 8'h5) <= 8'h2}, 32'h1);
        end
        finish_test();
    end
endmodule
